// file: include/sbrg_pkg.sv
// constants, types and helper functions of the serial baud rate generator
package sbrg_pkg;

   // system clock
   localparam int SYS_CLK_HZ = 40_000_000;

   // register map (byte offsets on the plain register port)
   localparam int ADDR_W = 3;
   localparam logic [2:0] OFS_BAUD_RATE_CONTROL = 3'h0;
   localparam logic [2:0] OFS_RECEIVE_STATUS_CONTROL = 3'h1;
   localparam logic [2:0] OFS_DIVISOR_LOW_BYTE = 3'h2;
   localparam logic [2:0] OFS_DIVISOR_HIGH_BYTE = 3'h3;
   localparam logic [2:0] OFS_TRANSMIT_STATUS_CONTROL = 3'h4;

   // transmit_status_control fields
   localparam int TX_CLOCK_MASTER_BIT = 7;
   localparam int TX_NINE_BIT_BIT = 6;
   localparam int TX_ENABLE_BIT = 5;
   localparam int TX_SYNC_MODE_BIT = 4;
   localparam int TX_SEND_BREAK_BIT = 3;
   localparam int TX_HIGH_SPEED_SELECT_BIT = 2;
   localparam int TX_SHIFT_EMPTY_BIT = 1;
   localparam int TX_NINTH_DATA_BIT = 0;

   // receive_status_control fields
   localparam int RX_PORT_ENABLE_BIT = 7;
   localparam int RX_NINE_BIT_BIT = 6;
   localparam int RX_SINGLE_ENABLE_BIT = 5;
   localparam int RX_CONT_ENABLE_BIT = 4;
   localparam int RX_ADDR_DETECT_BIT = 3;
   localparam int RX_FRAME_ERR_BIT = 2;
   localparam int RX_OVERRUN_BIT = 1;
   localparam int RX_NINTH_DATA_BIT = 0;

   // baud_rate_control fields
   localparam int BC_AUTOBAUD_OVF_BIT = 7;
   localparam int BC_RECEIVE_IDLE_FLAG_BIT = 6;
   localparam int BC_CLOCK_POLARITY_BIT = 4;
   localparam int BC_WIDE_DIVIDER_SELECT_BIT = 3;
   localparam int BC_WAKE_ENABLE_BIT = 1;
   localparam int BC_AUTOBAUD_ENABLE_BIT = 0;

   // software-writable bits of each control register
   localparam logic [7:0] TX_WRITE_MASK = 8'hfd;
   localparam logic [7:0] RX_WRITE_MASK = 8'hf8;
   localparam logic [7:0] BC_WRITE_MASK = 8'h1b;

   // reset values of the stored bits
   localparam logic [7:0] TX_RESET = 8'h00;
   localparam logic [7:0] RX_RESET = 8'h00;
   localparam logic [7:0] BC_RESET = 8'h00;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic RX_IDLE_RESET = 1'b1;

   // rate multipliers
   localparam int MUL_ASYNC_SLOW_8 = 64;
   localparam int MUL_ASYNC_MID = 16;
   localparam int MUL_FAST = 4;
   localparam int PRESCALE_W = 6;

   typedef enum logic [1:0] {MUL_BY_64, MUL_BY_16, MUL_BY_4} sbrg_mul_type;

   // multiplier from mode, width and high speed select
   function automatic sbrg_mul_type sbrg_mul_select(input logic sync, input logic wide, input logic high);
      sbrg_mul_type m;
      if (sync)
         m = MUL_BY_4;
      else if (wide && high)
         m = MUL_BY_4;
      else if (wide || high)
         m = MUL_BY_16;
      else
         m = MUL_BY_64;
      return m;
   endfunction

   // terminal count of the prescaler, one below the multiplier
   function automatic logic [PRESCALE_W-1:0] sbrg_mul_term(input sbrg_mul_type m);
      logic [PRESCALE_W-1:0] t;
      unique case (m)
         MUL_BY_64: t = PRESCALE_W'(MUL_ASYNC_SLOW_8 - 1);
         MUL_BY_16: t = PRESCALE_W'(MUL_ASYNC_MID - 1);
         MUL_BY_4: t = PRESCALE_W'(MUL_FAST - 1);
         default: t = PRESCALE_W'(MUL_FAST - 1);
      endcase
      return t;
   endfunction

endpackage

// file: hw/sbrg_prescale.sv
// rate multiplier prescaler: one enable pulse every 64, 16 or 4 clocks
`timescale 1ns/1ps
module sbrg_prescale
   import sbrg_pkg::*;
#(
   parameter int CNT_W = PRESCALE_W
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic restart,
   input wire sbrg_mul_type mul_sel,
   output logic pulse
);

   if (CNT_W < PRESCALE_W) begin : g_width_check
      $error("sbrg_prescale: CNT_W too small for the largest multiplier");
   end

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic pulse;
   } sbrg_pre_state_type;

   sbrg_pre_state_type st;
   sbrg_pre_state_type next_st;

   always_comb begin
      next_st = st;
      next_st.pulse = 1'b0;
      if (restart) begin
         // a divisor write restarts the whole period, prescaler included
         next_st.cnt = '0;
      end else if (st.cnt >= CNT_W'(sbrg_mul_term(mul_sel))) begin
         // >= so a narrower multiplier picked mid-count wraps at once
         next_st.cnt = '0;
         next_st.pulse = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 1'b1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RSTN)
         st <= '0;
      else
         st <= next_st;
   end

   assign pulse = st.pulse;

endmodule

// file: hw/sbrg_top.sv
// serial baud rate generator: control registers, baud timer and receive idle flag
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module sbrg_top
   import sbrg_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic RX_BUSY,
   input wire logic TX_SHIFT_EMPTY,
   input wire logic RX_FRAME_ERR,
   input wire logic RX_OVERRUN,
   input wire logic RX_NINTH,
   input wire logic AUTOBAUD_OVF,
   input wire logic BREAK_DONE,
   input wire logic SINGLE_DONE,
   input wire logic WAKE_DONE,
   input wire logic AUTOBAUD_DONE,
   output logic [7:0] RDATA,
   output logic BAUD_TICK,
   output logic RX_IDLE,
   output logic SYNC_MODE,
   output logic CLOCK_MASTER,
   output logic CLOCK_POLARITY,
   output logic PORT_ENABLE,
   output logic TX_ENABLE,
   output logic TX_NINE_BIT,
   output logic TX_NINTH_DATA,
   output logic SEND_BREAK,
   output logic RX_NINE_BIT,
   output logic RX_SINGLE_ENABLE,
   output logic RX_CONT_ENABLE,
   output logic ADDR_DETECT,
   output logic WAKE_ENABLE,
   output logic AUTOBAUD_ENABLE
);

   if (DIV_W != 16) begin : g_width_check
      $error("sbrg_top: divisor is a byte pair, DIV_W must be 16");
   end

   typedef struct packed {
      logic [7:0] transmit_status_control;
      logic [7:0] receive_status_control;
      logic [7:0] baud_rate_control;
      logic [7:0] divisor_low_byte;
      logic [7:0] divisor_high_byte;
      logic [DIV_W-1:0] baud_timer;
      logic tick;
      logic rx_idle;
      logic [7:0] rdata;
   } sbrg_state_type;

   sbrg_state_type st;
   sbrg_state_type next_st;

   logic wr_transmit_status_control;
   logic wr_receive_status_control;
   logic wr_baud_rate_control;
   logic wr_div_lo;
   logic wr_div_hi;
   logic div_write;
   logic sync_sel;
   logic wide_sel;
   logic high_sel;
   sbrg_mul_type mul_sel;
   logic pre_pulse;
   logic [DIV_W-1:0] limit;

   assign wr_transmit_status_control = WR && (ADDR == OFS_TRANSMIT_STATUS_CONTROL);
   assign wr_receive_status_control = WR && (ADDR == OFS_RECEIVE_STATUS_CONTROL);
   assign wr_baud_rate_control = WR && (ADDR == OFS_BAUD_RATE_CONTROL);
   assign wr_div_lo = WR && (ADDR == OFS_DIVISOR_LOW_BYTE);
   assign wr_div_hi = WR && (ADDR == OFS_DIVISOR_HIGH_BYTE);
   assign div_write = wr_div_lo || wr_div_hi;

   assign sync_sel = st.transmit_status_control[TX_SYNC_MODE_BIT];
   assign wide_sel = st.baud_rate_control[BC_WIDE_DIVIDER_SELECT_BIT];
   assign high_sel = st.transmit_status_control[TX_HIGH_SPEED_SELECT_BIT];

   // sync forces divide by 4 whatever high speed says
   assign mul_sel = sbrg_mul_select(sync_sel, wide_sel, high_sel);

   // 8-bit width takes the low byte only; the high byte is kept but unused
   assign limit = wide_sel ? {st.divisor_high_byte, st.divisor_low_byte} : {8'h00, st.divisor_low_byte};

   sbrg_prescale #(
      .CNT_W(PRESCALE_W)
   ) u_prescale (
      .MCLK(MCLK),
      .RSTN(RSTN),
      .restart(div_write),
      .mul_sel(mul_sel),
      .pulse(pre_pulse)
   );

   // readback with hardware status bits merged in
   function automatic logic [7:0] read_value(input sbrg_state_type s, input logic [ADDR_W-1:0] a,
                                             input logic shift_empty, input logic ferr, input logic oerr,
                                             input logic ninth, input logic abd_ovf);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         OFS_TRANSMIT_STATUS_CONTROL: begin
            v = s.transmit_status_control & TX_WRITE_MASK;
            v[TX_SHIFT_EMPTY_BIT] = shift_empty;
         end
         OFS_RECEIVE_STATUS_CONTROL: begin
            v = s.receive_status_control & RX_WRITE_MASK;
            v[RX_FRAME_ERR_BIT] = ferr;
            v[RX_OVERRUN_BIT] = oerr;
            v[RX_NINTH_DATA_BIT] = ninth;
         end
         OFS_BAUD_RATE_CONTROL: begin
            v = s.baud_rate_control & BC_WRITE_MASK;
            v[BC_AUTOBAUD_OVF_BIT] = abd_ovf;
            v[BC_RECEIVE_IDLE_FLAG_BIT] = s.rx_idle;
         end
         OFS_DIVISOR_LOW_BYTE: v = s.divisor_low_byte;
         OFS_DIVISOR_HIGH_BYTE: v = s.divisor_high_byte;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;

      // hardware clears of self-clearing bits; a software write this cycle wins below
      if (BREAK_DONE)
         next_st.transmit_status_control[TX_SEND_BREAK_BIT] = 1'b0;
      if (SINGLE_DONE)
         next_st.receive_status_control[RX_SINGLE_ENABLE_BIT] = 1'b0;
      if (WAKE_DONE)
         next_st.baud_rate_control[BC_WAKE_ENABLE_BIT] = 1'b0;
      if (AUTOBAUD_DONE)
         next_st.baud_rate_control[BC_AUTOBAUD_ENABLE_BIT] = 1'b0;

      if (wr_transmit_status_control)
         next_st.transmit_status_control = WDATA & TX_WRITE_MASK;
      if (wr_receive_status_control)
         next_st.receive_status_control = WDATA & RX_WRITE_MASK;
      if (wr_baud_rate_control)
         next_st.baud_rate_control = WDATA & BC_WRITE_MASK;
      if (wr_div_lo)
         next_st.divisor_low_byte = WDATA;
      if (wr_div_hi)
         next_st.divisor_high_byte = WDATA;

      // the same free-running timer feeds transmitter and receiver in both modes
      if (div_write) begin
         next_st.baud_timer = '0;
      end else if (pre_pulse) begin
         // >= guards a drop from 16-bit to 8-bit width leaving the count above the limit
         if (st.baud_timer >= limit) begin
            next_st.baud_timer = '0;
            next_st.tick = 1'b1;
         end else begin
            next_st.baud_timer = st.baud_timer + 1'b1;
         end
      end

      // receiver busy comes from same-clock logic, no synchroniser needed
      next_st.rx_idle = !RX_BUSY;

      if (RD)
         next_st.rdata = read_value(st, ADDR, TX_SHIFT_EMPTY, RX_FRAME_ERR, RX_OVERRUN, RX_NINTH, AUTOBAUD_OVF);
      else
         next_st.rdata = 8'h00;
   end

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         st.transmit_status_control <= TX_RESET;
         st.receive_status_control <= RX_RESET;
         st.baud_rate_control <= BC_RESET;
         st.divisor_low_byte <= DIV_RESET;
         st.divisor_high_byte <= DIV_RESET;
         st.baud_timer <= '0;
         st.tick <= 1'b0;
         st.rx_idle <= RX_IDLE_RESET;
         st.rdata <= 8'h00;
      end else begin
         st <= next_st;
      end
   end

   assign RDATA = st.rdata;
   assign BAUD_TICK = st.tick;
   assign RX_IDLE = st.rx_idle;
   assign SYNC_MODE = st.transmit_status_control[TX_SYNC_MODE_BIT];
   assign CLOCK_MASTER = st.transmit_status_control[TX_CLOCK_MASTER_BIT];
   assign CLOCK_POLARITY = st.baud_rate_control[BC_CLOCK_POLARITY_BIT];
   assign PORT_ENABLE = st.receive_status_control[RX_PORT_ENABLE_BIT];
   assign TX_ENABLE = st.transmit_status_control[TX_ENABLE_BIT];
   assign TX_NINE_BIT = st.transmit_status_control[TX_NINE_BIT_BIT];
   assign TX_NINTH_DATA = st.transmit_status_control[TX_NINTH_DATA_BIT];
   assign SEND_BREAK = st.transmit_status_control[TX_SEND_BREAK_BIT];
   assign RX_NINE_BIT = st.receive_status_control[RX_NINE_BIT_BIT];
   assign RX_SINGLE_ENABLE = st.receive_status_control[RX_SINGLE_ENABLE_BIT];
   assign RX_CONT_ENABLE = st.receive_status_control[RX_CONT_ENABLE_BIT];
   assign ADDR_DETECT = st.receive_status_control[RX_ADDR_DETECT_BIT];
   assign WAKE_ENABLE = st.baud_rate_control[BC_WAKE_ENABLE_BIT];
   assign AUTOBAUD_ENABLE = st.baud_rate_control[BC_AUTOBAUD_ENABLE_BIT];

endmodule

// file: verif/sbrg_checker.sv
// port assertions for the baud rate generator
`timescale 1ns/1ps
module sbrg_checker
   import sbrg_pkg::*;
(
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic RX_BUSY,
   input wire logic [7:0] RDATA,
   input wire logic BAUD_TICK,
   input wire logic RX_IDLE,
   input wire logic SYNC_MODE
);
   logic [7:0] hi;
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         hi <= 8'h00;
      end else if (WR && ADDR == OFS_DIVISOR_HIGH_BYTE) begin
         hi <= WDATA;
      end
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   sequence s_wr_lo; WR && ADDR == OFS_DIVISOR_LOW_BYTE; endsequence
   sequence s_sync_zero; s_wr_lo ##0 (WDATA == 8'h00 && hi == 8'h00 && SYNC_MODE); endsequence
   // prescaler pulse and timer compare each add a register, so the first tick is seen on the sixth edge
   sequence s_sync_ticks; !BAUD_TICK[*5] ##1 BAUD_TICK ##1 !BAUD_TICK[*3] ##1 BAUD_TICK; endsequence
   property p_sync_zero; s_sync_zero |=> s_sync_ticks; endproperty
   property p_clear; WR && (ADDR == OFS_DIVISOR_LOW_BYTE || ADDR == OFS_DIVISOR_HIGH_BYTE) |-> ##2 !BAUD_TICK[*3];
   endproperty
   property p_tick_pulse; BAUD_TICK |=> !BAUD_TICK; endproperty
   property p_idle; $past(RSTN) |-> RX_IDLE == !$past(RX_BUSY); endproperty
   property p_idle_read; RD && ADDR == OFS_BAUD_RATE_CONTROL |=> RDATA[BC_RECEIVE_IDLE_FLAG_BIT] == $past(RX_IDLE);
   endproperty
   property p_b2b; s_wr_lo ##1 (RD && ADDR == OFS_DIVISOR_LOW_BYTE) |=> RDATA == $past(WDATA, 2); endproperty
   property p_tx_sync; RD && ADDR == OFS_TRANSMIT_STATUS_CONTROL |=> RDATA[TX_SYNC_MODE_BIT] == $past(SYNC_MODE);
   endproperty
   property p_unmapped; RD && ADDR > OFS_TRANSMIT_STATUS_CONTROL |=> RDATA == 8'h00; endproperty
   property p_reset; $rose(RSTN) |-> RX_IDLE && !BAUD_TICK && RDATA == 8'h00; endproperty
   a_sync_zero: assert property (p_sync_zero) else $error("sync tick spacing wrong");
   a_clear: assert property (p_clear) else $error("tick too soon after divisor write");
   a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");
   a_idle: assert property (p_idle) else $error("idle flag does not follow busy");
   a_idle_read: assert property (p_idle_read) else $error("idle flag read wrong");
   a_b2b: assert property (p_b2b) else $error("divisor low readback wrong");
   a_tx_sync: assert property (p_tx_sync) else $error("sync mode read wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_reset: assert property (p_reset) else $error("outputs wrong after reset");
endmodule
bind sbrg_top sbrg_checker chk (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RX_BUSY(RX_BUSY), .RDATA(RDATA), .BAUD_TICK(BAUD_TICK), .RX_IDLE(RX_IDLE), .SYNC_MODE(SYNC_MODE));

// file: verif/sbrg_top_tb.sv
// self-checking testbench for the baud rate generator
`timescale 1ns/1ps
module sbrg_top_tb;
   import sbrg_pkg::*;
   logic MCLK, RSTN, WR, RD, RX_BUSY, TX_SHIFT_EMPTY, RX_FRAME_ERR, RX_OVERRUN, RX_NINTH, AUTOBAUD_OVF;
   logic BREAK_DONE, SINGLE_DONE, WAKE_DONE, AUTOBAUD_DONE, BAUD_TICK, RX_IDLE;
   logic SYNC_MODE, CLOCK_MASTER, CLOCK_POLARITY, PORT_ENABLE, TX_ENABLE, TX_NINE_BIT, TX_NINTH_DATA, SEND_BREAK;
   logic RX_NINE_BIT, RX_SINGLE_ENABLE, RX_CONT_ENABLE, ADDR_DETECT, WAKE_ENABLE, AUTOBAUD_ENABLE;
   logic [ADDR_W-1:0] ADDR;
   logic [7:0] WDATA, RDATA, v;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   sbrg_top dut (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RX_BUSY(RX_BUSY),
      .TX_SHIFT_EMPTY(TX_SHIFT_EMPTY), .RX_FRAME_ERR(RX_FRAME_ERR), .RX_OVERRUN(RX_OVERRUN), .RX_NINTH(RX_NINTH),
      .AUTOBAUD_OVF(AUTOBAUD_OVF), .BREAK_DONE(BREAK_DONE), .SINGLE_DONE(SINGLE_DONE), .WAKE_DONE(WAKE_DONE),
      .AUTOBAUD_DONE(AUTOBAUD_DONE), .RDATA(RDATA), .BAUD_TICK(BAUD_TICK), .RX_IDLE(RX_IDLE), .SYNC_MODE(SYNC_MODE),
      .CLOCK_MASTER(CLOCK_MASTER), .CLOCK_POLARITY(CLOCK_POLARITY), .PORT_ENABLE(PORT_ENABLE), .TX_ENABLE(TX_ENABLE),
      .TX_NINE_BIT(TX_NINE_BIT), .TX_NINTH_DATA(TX_NINTH_DATA), .SEND_BREAK(SEND_BREAK), .RX_NINE_BIT(RX_NINE_BIT),
      .RX_SINGLE_ENABLE(RX_SINGLE_ENABLE), .RX_CONT_ENABLE(RX_CONT_ENABLE), .ADDR_DETECT(ADDR_DETECT),
      .WAKE_ENABLE(WAKE_ENABLE), .AUTOBAUD_ENABLE(AUTOBAUD_ENABLE));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // bus tasks are entered right after a rising edge and return on one
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 v = RDATA;
      @(posedge MCLK);
   endtask
   task automatic wait_tick(output int cnt);
      cnt = 0;
      do begin
         @(posedge MCLK);
         #1 cnt++;
      end while (BAUD_TICK !== 1'b1 && cnt < 3000);
   endtask
   task automatic tick_case(input logic [7:0] tx, bc, hi, lo, input int m, n);
      int cnt;
      wr(OFS_TRANSMIT_STATUS_CONTROL, tx);
      wr(OFS_BAUD_RATE_CONTROL, bc);
      wr(OFS_DIVISOR_HIGH_BYTE, hi);
      ADDR <= OFS_DIVISOR_LOW_BYTE;
      WDATA <= lo;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
      wait_tick(cnt);
      check(16'(cnt), 16'(m * (n + 1) + 1));
      wait_tick(cnt);
      check(16'(cnt), 16'(m * (n + 1)));
      @(posedge MCLK);
      $display("rate case tx %h bc %h done", tx, bc);
   endtask
   task automatic t_reset;
      logic [7:0] exp [8];
      exp = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 8; i++) begin
         rd(ADDR_W'(i));
         check(16'(v), 16'(exp[i]));
      end
      $display("reset values test done");
   endtask
   task automatic t_regs;
      ADDR <= OFS_DIVISOR_LOW_BYTE;
      WDATA <= 8'h5a;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 check(16'(RDATA), 16'h005a);
      @(posedge MCLK);
      #1 check(16'(RDATA), 16'h0000);
      @(posedge MCLK);
      wr(OFS_BAUD_RATE_CONTROL, 8'hff);
      rd(OFS_BAUD_RATE_CONTROL);
      check(16'(v), 16'h005b);
      wr(3'h5, 8'hff);
      rd(3'h5);
      check(16'(v), 16'h0000);
      wr(OFS_BAUD_RATE_CONTROL, 8'h00);
      $display("register access test done");
   endtask
   task automatic t_idle;
      RX_BUSY <= 1'b1;
      @(posedge MCLK);
      #1 check(16'(RX_IDLE), 16'h0000);
      @(posedge MCLK);
      rd(OFS_BAUD_RATE_CONTROL);
      check(16'(v), 16'h0000);
      RX_BUSY <= 1'b0;
      @(posedge MCLK);
      #1 check(16'(RX_IDLE), 16'h0001);
      @(posedge MCLK);
      $display("receive idle test done");
   endtask
   task automatic t_ctrl;
      wr(OFS_TRANSMIT_STATUS_CONTROL, 8'hff);
      wr(OFS_RECEIVE_STATUS_CONTROL, 8'hff);
      wr(OFS_BAUD_RATE_CONTROL, 8'hff);
      #1 check(16'({CLOCK_MASTER, TX_NINE_BIT, TX_ENABLE, SYNC_MODE, SEND_BREAK, TX_NINTH_DATA}), 16'h003f);
      check(16'({PORT_ENABLE, RX_NINE_BIT, RX_SINGLE_ENABLE, RX_CONT_ENABLE, ADDR_DETECT}), 16'h001f);
      check(16'({CLOCK_POLARITY, WAKE_ENABLE, AUTOBAUD_ENABLE}), 16'h0007);
      @(posedge MCLK);
      // live status inputs must show through the readback, shift empty low this time
      {TX_SHIFT_EMPTY, RX_FRAME_ERR, RX_NINTH, AUTOBAUD_OVF} <= 4'h7;
      rd(OFS_TRANSMIT_STATUS_CONTROL);
      check(16'(v), 16'h00fd);
      rd(OFS_RECEIVE_STATUS_CONTROL);
      check(16'(v), 16'h00fd);
      rd(OFS_BAUD_RATE_CONTROL);
      check(16'(v), 16'h00db);
      {BREAK_DONE, SINGLE_DONE, WAKE_DONE, AUTOBAUD_DONE} <= 4'hf;
      @(posedge MCLK);
      {BREAK_DONE, SINGLE_DONE, WAKE_DONE, AUTOBAUD_DONE} <= 4'h0;
      {TX_SHIFT_EMPTY, RX_FRAME_ERR, RX_NINTH, AUTOBAUD_OVF} <= 4'h8;
      #1 check(16'({SEND_BREAK, RX_SINGLE_ENABLE, WAKE_ENABLE, AUTOBAUD_ENABLE, TX_ENABLE, PORT_ENABLE}), 16'h0003);
      @(posedge MCLK);
      // a software set in the same cycle as the hardware clear must win
      ADDR <= OFS_TRANSMIT_STATUS_CONTROL;
      WDATA <= 8'h08;
      WR <= 1'b1;
      BREAK_DONE <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
      BREAK_DONE <= 1'b0;
      #1 check(16'(SEND_BREAK), 16'h0001);
      @(posedge MCLK);
      wr(OFS_TRANSMIT_STATUS_CONTROL, 8'h00);
      wr(OFS_RECEIVE_STATUS_CONTROL, 8'h00);
      wr(OFS_BAUD_RATE_CONTROL, 8'h00);
      $display("control register test done");
   endtask
   initial begin
      MCLK = 1'b0;
      forever #12.5 MCLK = ~MCLK;
   end
   // the full run needs about 3000 cycles
   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 10000) begin
         n_errors++;
         finish_test;
      end
   end
   initial begin
      {RSTN, WR, RD, RX_BUSY, RX_FRAME_ERR, RX_OVERRUN, RX_NINTH, AUTOBAUD_OVF} = 8'h00;
      {BREAK_DONE, SINGLE_DONE, WAKE_DONE, AUTOBAUD_DONE} = 4'h0;
      TX_SHIFT_EMPTY = 1'b1;
      ADDR = '0;
      WDATA = 8'h00;
      repeat (4) @(posedge MCLK);
      RSTN <= 1'b1;
      @(posedge MCLK);
      t_reset;
      t_regs;
      t_idle;
      t_ctrl;
      tick_case(8'h00, 8'h00, 8'h01, 8'h01, 64, 1);
      tick_case(8'h04, 8'h00, 8'h00, 8'h02, 16, 2);
      tick_case(8'h00, 8'h08, 8'h00, 8'h03, 16, 3);
      tick_case(8'h04, 8'h08, 8'h00, 8'h01, 4, 1);
      tick_case(8'h14, 8'h00, 8'h01, 8'h00, 4, 0);
      tick_case(8'h14, 8'h08, 8'h00, 8'h00, 4, 0);
      tick_case(8'h10, 8'h08, 8'h01, 8'h00, 4, 256);
      finish_test;
   end
endmodule
